// ===== sim/scp_core_bench.sv
// Self-checking bench for the serial command port.
`timescale 1ns/1ps
module scp_core_bench;
  import scp_pkg::*;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst_n = 1'b0, select_polarity_strap = 1'b0, cpol = 1'b0, cpha = 1'b0;
  logic wake = 1'b0, key_n = 1'b1, tmode = 1'b0, rxs = 1'b0;
  logic wev = 1'b0, rev = 1'b0, iev = 1'b0;
  logic [4:0] cnt = 5'h00, nb = 5'h00, a, raddr, thr;
  logic [7:0] rdat = 8'h00, rrd = 8'h00, v0, v1, wdat, rwdat, hrx;
  logic cs, sck, sdi, so, so_oe, pop, push, reg_wr, irq, poff, allow, hstb;
  logic [15:0] ev;
  logic [7:0] regs [32];
  logic [7:0] fifo[$], bq[$];
  logic [15:0] q_ev[$];
  logic [8:0] q_rx[$];
  int failures = 0, n_tests = 0, cyc = 0, seed_v;

  always #12.5 clk = ~clk;

  scp_core scp_core_i (
    .CLK(clk), .RST_N(rst_n), .CS_PIN(cs), .SCK_PIN(sck),
    .SERIAL_IN_PIN(sdi), .SELECT_POLARITY_STRAP(select_polarity_strap),
    .CLOCK_POLARITY_STRAP(cpol), .CLOCK_PHASE_STRAP(cpha),
    .WAKE_PIN_HIGH_ACTIVE(wake), .KEY_WAKE_PIN_LOW_ACTIVE(key_n),
    .SERIAL_OUT_PIN_O(so), .SERIAL_OUT_PIN_OE(so_oe),
    .TRANSPARENT_MODE(tmode), .RX_STREAM(rxs), .BUF_COUNT(cnt),
    .BUF_RD_DATA(rdat), .BUF_POP(pop), .BUF_PUSH(push),
    .BUF_WR_DATA(wdat), .REG_ADDR(raddr), .REG_WR(reg_wr),
    .REG_WR_DATA(rwdat), .REG_RD_DATA(rrd), .TX_START_THRESHOLD(thr),
    .TX_START_ALLOW(allow), .WAKE_EVENT(wev), .RAM_LOW_EVENT(rev),
    .IRQ_EVENT(iev), .IRQ(irq), .POWER_OFF(poff)
  );
  scp_host scp_host_i (
    .clk(clk), .select_polarity_strap(select_polarity_strap), .cpol(cpol), .cpha(cpha), .so(so),
    .so_oe(so_oe), .cs(cs), .sck(sck), .sdi(sdi), .rx(hrx), .rx_stb(hstb)
  );

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic complete_run();
    $display("Counts: %0d checks, %0d failures", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Bit 8 of a note marks a byte whose value matters.
  task automatic xb(input logic [7:0] d, input logic [8:0] e);
    q_rx.push_back(e);
    scp_host_i.xfer(d);
  endtask : xb

  task automatic cmd(input logic [7:0] c);
    scp_host_i.start();
    xb(c, {1'b1, 3'h0, nb});
  endtask : cmd

  task automatic pulse(input logic [2:0] m);
    {wev, rev, iev} = m;
    @(negedge clk);
    {wev, rev, iev} = 3'h0;
    repeat (3) @(negedge clk);
  endtask : pulse

  // Far-end buffer and register file, driven off the sampling edge.
  always @(negedge clk)
  begin
    if ((reg_wr | push | pop | poff) === 1'b1)
    begin
      ev = reg_wr ? {3'h1, raddr - 5'h01, rwdat} :
        push ? {3'h2, 5'h00, wdat} : pop ? 16'h6000 : 16'h8000;
      chk("event", q_ev.size() > 0 ? q_ev[0] : 16'hFFFF, ev);
      if (q_ev.size() > 0)
        void'(q_ev.pop_front());
    end
    if (reg_wr === 1'b1)
      regs[raddr - 5'h01] = rwdat;
    if (pop === 1'b1 && fifo.size() > 0)
      void'(fifo.pop_front());
    if (push === 1'b1)
      fifo.push_back(wdat);
    cnt <= 5'(fifo.size());
    rdat <= fifo.size() > 0 ? fifo[0] : 8'h00;
    rrd <= regs[raddr];
  end

  always @(posedge clk)
  begin
    cyc++;
    if (hstb === 1'b1)
    begin
      if (q_rx[0][8])
        chk("serial_out", 16'(q_rx[0][7:0]), 16'(hrx));
      void'(q_rx.pop_front());
    end
    if (cyc == LIMIT)
    begin
      failures++;
      complete_run();
    end
  end

  initial
  begin
    seed_v = $urandom(32928);
    foreach (regs[i])
      regs[i] = 8'($urandom);
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    scp_host_i.idle();
    chk("oe_idle", 16'h0000, 16'(so_oe));
    tmode = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      rxs = k[0];
      repeat (3) @(negedge clk);
      chk("transparent", {14'h0, 1'b1, rxs}, {14'h0, so_oe, so});
    end
    tmode = 1'b0;
    $display("Test transparent output done");
    for (int m = 0; m < 8; m++)
    begin
      {select_polarity_strap, cpol, cpha} = 3'(m);
      scp_host_i.idle();
      a = 5'($urandom_range(0, 13));
      v0 = 8'($urandom);
      v1 = 8'($urandom);
      q_ev.push_back({3'h1, a, v0});
      q_ev.push_back({3'h1, a + 5'h01, v1});
      cmd({CMD_WR_REG, a});
      xb(v0, 9'h000);
      xb(v1, 9'h000);
      scp_host_i.end_frame();
      cmd({CMD_RD_REG, a});
      xb(8'h00, {1'b1, v0});
      xb(8'h00, {1'b1, v1});
      scp_host_i.end_frame();
      $display("Test serial mode %0d done", m);
    end
    cmd({CMD_WR_BUF, 5'h00});
    scp_host_i.end_frame();
    chk("threshold", 16'h0000, 16'(thr));
    chk("tx_allow", 16'h0000, 16'(allow));
    for (int k = 0; k < 2; k++)
    begin
      cmd({CMD_WR_BUF, 5'h03});
      for (int j = 0; j < 2 - k; j++)
      begin
        v0 = 8'($urandom);
        bq.push_back(v0);
        q_ev.push_back({3'h2, 5'h00, v0});
        xb(v0, 9'h000);
        nb++;
      end
      scp_host_i.end_frame();
      chk("threshold", 16'h0003, 16'(thr));
      chk("tx_allow", 16'(k), 16'(allow));
    end
    cmd({CMD_RD_BUF, 5'h00});
    while (bq.size() > 0)
    begin
      q_ev.push_back(16'h6000);
      xb(8'h00, {1'b1, bq.pop_front()});
      nb--;
    end
    scp_host_i.end_frame();
    $display("Test data buffer done");
    pulse(3'h6);
    chk("irq_set", 16'h0001, 16'(irq));
    for (int k = 0; k < 2; k++)
    begin
      cmd({CMD_RD_REG, STATUS_ADDR});
      xb(8'h00, k == 0 ? 9'h106 : 9'h100);
      scp_host_i.end_frame();
      chk("irq_status", 16'h0000, 16'(irq));
    end
    pulse(3'h1);
    chk("irq_set", 16'h0001, 16'(irq));
    cmd(8'hBF);
    scp_host_i.end_frame();
    chk("irq_clear", 16'h0000, 16'(irq));
    $display("Test status and interrupt done");
    for (int k = 0; k < 3; k++)
    begin
      {wake, key_n} = k == 0 ? 2'h3 : k == 1 ? 2'h0 : 2'h1;
      repeat (4) @(negedge clk);
      if (k == 2)
        q_ev.push_back(16'h8000);
      cmd(k == 2 ? 8'h9F : 8'h80);
      scp_host_i.end_frame();
    end
    for (int k = 6; k < 8; k++)
    begin
      cmd({3'(k), 5'h15});
      xb(8'($urandom), 9'h000);
      xb(8'($urandom), 9'h000);
      scp_host_i.end_frame();
    end
    chk("threshold", 16'h0003, 16'(thr));
    $display("Test power off and unused codes done");
    repeat (20) @(negedge clk);
    chk("pending", 16'h0000, 16'(q_ev.size() + q_rx.size()));
    complete_run();
  end
endmodule : scp_core_bench

// ===== sim/scp_host.sv
// Host serial master model that drives the command port pins.
`timescale 1ns/1ps
module scp_host (
  input wire logic clk,
  input wire logic select_polarity_strap,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic so,
  input wire logic so_oe,
  output logic cs,
  output logic sck,
  output logic sdi,
  output logic [7:0] rx,
  output logic rx_stb
);
  logic last_v = 1'b0;
  logic miso;
  // A floating line reads as the inverse of its last driven level.
  assign miso = so_oe ? so : ~last_v;
  always @(negedge clk)
  begin
    if (so_oe === 1'b1)
      last_v <= so;
  end
  initial
  begin
    {cs, sck, sdi, rx_stb} = 4'h0;
    rx = 8'h00;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  // Select and clock idle levels move together with the straps.
  task automatic idle();
    cs = select_polarity_strap;
    sck = cpol;
    wait_n(10);
  endtask : idle
  task automatic start();
    cs = ~select_polarity_strap;
    wait_n(8);
  endtask : start
  task automatic end_frame();
    wait_n(4);
    cs = select_polarity_strap;
    wait_n(10);
  endtask : end_frame
  task automatic xfer(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      if (!cpha)
        sdi = d[i];
      wait_n(4);
      sck = ~cpol;
      if (cpha)
        sdi = d[i];
      else
        r[i] = miso;
      wait_n(4);
      sck = cpol;
      if (cpha)
        r[i] = miso;
    end
    rx = r;
    rx_stb = 1'b1;
    wait_n(1);
    rx_stb = 1'b0;
  endtask : xfer
endmodule : scp_host

// ===== src/scp_core.sv
// Serial command port: command decode, data shifting and status flags.
`timescale 1ns/1ps
module scp_core (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CS_PIN,
  input wire logic SCK_PIN,
  input wire logic SERIAL_IN_PIN,
  input wire logic SELECT_POLARITY_STRAP,
  input wire logic CLOCK_POLARITY_STRAP,
  input wire logic CLOCK_PHASE_STRAP,
  input wire logic WAKE_PIN_HIGH_ACTIVE,
  input wire logic KEY_WAKE_PIN_LOW_ACTIVE,
  output logic SERIAL_OUT_PIN_O,
  output logic SERIAL_OUT_PIN_OE,
  input wire logic TRANSPARENT_MODE,
  input wire logic RX_STREAM,
  input wire logic [scp_pkg::CNT_W-1:0] BUF_COUNT,
  input wire logic [scp_pkg::BYTE_W-1:0] BUF_RD_DATA,
  output logic BUF_POP,
  output logic BUF_PUSH,
  output logic [scp_pkg::BYTE_W-1:0] BUF_WR_DATA,
  output logic [scp_pkg::ADDR_W-1:0] REG_ADDR,
  output logic REG_WR,
  output logic [scp_pkg::BYTE_W-1:0] REG_WR_DATA,
  input wire logic [scp_pkg::BYTE_W-1:0] REG_RD_DATA,
  output logic [scp_pkg::CNT_W-1:0] TX_START_THRESHOLD,
  output logic TX_START_ALLOW,
  input wire logic WAKE_EVENT,
  input wire logic RAM_LOW_EVENT,
  input wire logic IRQ_EVENT,
  output logic IRQ,
  output logic POWER_OFF
);

  import scp_pkg::*;

  scp_pins_t pins_raw;
  scp_pins_t pins;
  scp_cmd_t cmd;
  scp_state_t state_reg;

  logic cs_act;
  logic cs_prev_reg;
  logic cs_start;
  logic sck_prev_reg;
  logic lead, trail, sample_edge, shift_edge;
  logic [2:0] bit_cnt_reg;
  logic got_bit_reg;
  logic [BYTE_W-1:0] rx_sr_reg;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] tx_sr_reg;
  logic [BYTE_W-1:0] tx_next;
  logic [BYTE_W-1:0] status_byte;
  logic byte_done, cmd_done, data_done, status_read_done;
  logic wake_by_pin_flag_reg, ram_supply_low_flag_reg;
  logic [CNT_W-1:0] min_count;

  assign pins_raw = {CS_PIN, SCK_PIN, SERIAL_IN_PIN, SELECT_POLARITY_STRAP,
                     CLOCK_POLARITY_STRAP, CLOCK_PHASE_STRAP,
                     WAKE_PIN_HIGH_ACTIVE, KEY_WAKE_PIN_LOW_ACTIVE};

  // Straps pass the synchroniser too, so a strap changed live cannot glitch.
  scp_sync #(.W($bits(scp_pins_t))) scp_sync_i (
    .clk(CLK),
    .rst_n(RST_N),
    .d(pins_raw),
    .q(pins)
  );

  assign cs_act = pins.cs ^ pins.select_polarity_strap;
  assign cs_start = cs_act & ~cs_prev_reg;

  // Edges are seen in the idle-relative sense, so one decoder serves all modes.
  assign lead = cs_act & (pins.sck ^ pins.cpol) & ~(sck_prev_reg ^ pins.cpol);
  assign trail = cs_act & ~(pins.sck ^ pins.cpol) & (sck_prev_reg ^ pins.cpol);
  assign sample_edge = pins.cpha ? trail : lead;
  assign shift_edge = pins.cpha ? lead : trail;

  assign rx_byte = {rx_sr_reg[BYTE_W-2:0], pins.sdi};
  assign cmd = rx_byte;
  assign byte_done = sample_edge & (bit_cnt_reg == BIT_LAST);
  assign cmd_done = byte_done & (state_reg == ST_CMD);
  assign data_done = byte_done & (state_reg != ST_CMD);
  assign status_read_done = data_done & (state_reg == ST_RD_REG)
                            & (REG_ADDR == STATUS_ADDR);

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cs_prev_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
    end
    else
    begin
      cs_prev_reg <= cs_act;
      sck_prev_reg <= pins.sck;
    end
  end

  // Input shifter; a released select always restarts at a command byte.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      bit_cnt_reg <= BIT_FIRST;
      got_bit_reg <= 1'b0;
      rx_sr_reg <= BYTE_RST;
    end
    else if (!cs_act)
    begin
      bit_cnt_reg <= BIT_FIRST;
      got_bit_reg <= 1'b0;
      rx_sr_reg <= BYTE_RST;
    end
    else if (sample_edge)
    begin
      bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
      got_bit_reg <= 1'b1;
      rx_sr_reg <= rx_byte;
    end
  end

  // Command decode; the low bits matter only where the type uses them.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_reg <= ST_CMD;
    end
    else if (!cs_act)
    begin
      state_reg <= ST_CMD;
    end
    else if (cmd_done)
    begin
      case (cmd.kind)
        CMD_RD_BUF: state_reg <= ST_RD_BUF;
        CMD_WR_BUF: state_reg <= ST_WR_BUF;
        CMD_RD_REG: state_reg <= ST_RD_REG;
        CMD_WR_REG: state_reg <= ST_WR_REG;
        default: state_reg <= ST_IGNORE;
      endcase
    end
  end

  always_comb
  begin
    status_byte = BYTE_RST;
    status_byte[ST_KEY_BIT] = ~pins.key_n;
    status_byte[ST_WAKE_BIT] = wake_by_pin_flag_reg;
    status_byte[ST_RAM_BIT] = ram_supply_low_flag_reg;
  end

  // Read data is only peeked here; removal waits for the byte to complete,
  // because a trailing shift edge after the last byte must not lose data.
  always_comb
  begin
    case (state_reg)
      ST_RD_BUF: tx_next = BUF_RD_DATA;
      ST_RD_REG:
      begin
        if (REG_ADDR == STATUS_ADDR)
        begin
          tx_next = status_byte;
        end
        else
        begin
          tx_next = REG_RD_DATA;
        end
      end
      default: tx_next = BYTE_RST;
    endcase
  end

  // Output shifter; the first shift edge of phase 1 precedes any sample.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      tx_sr_reg <= BYTE_RST;
    end
    else if (cs_start)
    begin
      tx_sr_reg <= {{(BYTE_W-CNT_W){1'b0}}, BUF_COUNT};
    end
    else if (shift_edge && got_bit_reg)
    begin
      tx_sr_reg <= (bit_cnt_reg == BIT_FIRST) ? tx_next :
                   {tx_sr_reg[BYTE_W-2:0], 1'b0};
    end
  end

  // While deselected the pin carries the received stream in transparent mode.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      SERIAL_OUT_PIN_OE <= 1'b0;
      SERIAL_OUT_PIN_O <= 1'b0;
    end
    else
    begin
      SERIAL_OUT_PIN_OE <= cs_act | TRANSPARENT_MODE;
      SERIAL_OUT_PIN_O <= cs_act ? tx_sr_reg[BYTE_W-1] :
                          (TRANSPARENT_MODE & RX_STREAM);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      REG_ADDR <= ADDR_RST;
    end
    else if (cmd_done && (cmd.kind == CMD_RD_REG || cmd.kind == CMD_WR_REG))
    begin
      REG_ADDR <= cmd.arg;
    end
    else if (data_done && (state_reg == ST_RD_REG || state_reg == ST_WR_REG))
    begin
      REG_ADDR <= REG_ADDR + ADDR_STEP;
    end
  end

  // The status index is read only, so writes to it are dropped.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      REG_WR <= 1'b0;
      BUF_PUSH <= 1'b0;
      BUF_POP <= 1'b0;
      REG_WR_DATA <= BYTE_RST;
      BUF_WR_DATA <= BYTE_RST;
    end
    else
    begin
      REG_WR <= data_done && state_reg == ST_WR_REG
                && REG_ADDR != STATUS_ADDR;
      BUF_PUSH <= data_done && state_reg == ST_WR_BUF;
      BUF_POP <= data_done && state_reg == ST_RD_BUF;
      if (data_done && state_reg == ST_WR_REG)
      begin
        REG_WR_DATA <= rx_byte;
      end
      if (data_done && state_reg == ST_WR_BUF)
      begin
        BUF_WR_DATA <= rx_byte;
      end
    end
  end

  assign min_count = (TX_START_THRESHOLD < MIN_TX_BYTES) ? MIN_TX_BYTES :
                     TX_START_THRESHOLD;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      TX_START_THRESHOLD <= THRESH_RST;
      TX_START_ALLOW <= 1'b0;
    end
    else
    begin
      if (cmd_done && cmd.kind == CMD_WR_BUF)
      begin
        TX_START_THRESHOLD <= cmd.arg;
      end
      TX_START_ALLOW <= BUF_COUNT >= min_count;
    end
  end

  // Events win over a clear in the same cycle, so none is lost.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      wake_by_pin_flag_reg <= 1'b0;
      ram_supply_low_flag_reg <= 1'b0;
      IRQ <= 1'b0;
    end
    else
    begin
      if (WAKE_EVENT)
      begin
        wake_by_pin_flag_reg <= 1'b1;
      end
      else if (status_read_done)
      begin
        wake_by_pin_flag_reg <= 1'b0;
      end
      if (RAM_LOW_EVENT)
      begin
        ram_supply_low_flag_reg <= 1'b1;
      end
      else if (status_read_done)
      begin
        ram_supply_low_flag_reg <= 1'b0;
      end
      if (IRQ_EVENT || WAKE_EVENT)
      begin
        IRQ <= 1'b1;
      end
      else if (status_read_done || (cmd_done && cmd.kind == CMD_DEL_IRQ))
      begin
        IRQ <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      POWER_OFF <= 1'b0;
    end
    else
    begin
      POWER_OFF <= cmd_done && cmd.kind == CMD_OFF
                   && !pins.wake && pins.key_n;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_off_fire: assert property ((cmd_done && cmd.kind == CMD_OFF && !pins.wake
    && pins.key_n) |=> POWER_OFF ##1 !POWER_OFF)
    else $error("Power off did not pulse once.");
  a_off_block: assert property ((cmd_done && cmd.kind == CMD_OFF
    && (pins.wake || !pins.key_n)) |=> !POWER_OFF)
    else $error("Power off acted while a wake input was active.");
  a_irq_delete: assert property ((cmd_done && cmd.kind == CMD_DEL_IRQ
    && !IRQ_EVENT && !WAKE_EVENT) |=> !IRQ)
    else $error("Interrupt stayed high after clear command.");
  a_sdo_float: assert property ((!cs_act && !TRANSPARENT_MODE)
    |=> !SERIAL_OUT_PIN_OE)
    else $error("Serial output driven while deselected.");
  a_count_first: assert property (cs_start
    |=> tx_sr_reg[CNT_W-1:0] == $past(BUF_COUNT))
    else $error("Byte count not loaded at select.");
  a_tx_floor: assert property (TX_START_ALLOW |-> ($past(BUF_COUNT) != 0
    && $past(BUF_COUNT) >= $past(TX_START_THRESHOLD)))
    else $error("Transmit allowed below threshold.");
  a_ignore_quiet: assert property ((state_reg == ST_IGNORE)
    |=> (!BUF_PUSH && !BUF_POP && !REG_WR))
    else $error("Unused command touched buffer or registers.");
  a_pop_read: assert property ((data_done && state_reg == ST_RD_BUF)
    |=> BUF_POP ##1 !BUF_POP)
    else $error("Buffer read byte did not remove one entry.");
  a_push_byte: assert property ((data_done && state_reg == ST_WR_BUF)
    |=> BUF_PUSH && BUF_WR_DATA == $past(rx_byte))
    else $error("Buffer write byte not appended.");
  a_addr_step: assert property ((data_done && state_reg == ST_WR_REG)
    |=> REG_WR_DATA == $past(rx_byte) && REG_ADDR == $past(REG_ADDR) + 5'h01)
    else $error("Register write did not advance the index.");
  a_status_clear: assert property ((status_read_done && !WAKE_EVENT
    && !IRQ_EVENT && !RAM_LOW_EVENT) |=> !wake_by_pin_flag_reg
    && !ram_supply_low_flag_reg && !IRQ)
    else $error("Status read did not clear its flags and interrupt.");

endmodule : scp_core

// ===== src/scp_pkg.sv
// Constants, types and carriers shared by the serial command port.
// Notes on behaviour
// - Commands and data are eight-bit units, shifted MSB first with the clock.
// - While the command shifts in, the output carries the buffer byte count.
// - Command bits 7..5 pick the type; codes 110 and 111 are unused.
// - Register commands take bits 4..0 as the register index.
// - Buffer write takes bits 4..0 as start threshold; no start below it.
// - Transmission never starts empty, so thresholds zero and one match.
// - Other commands ignore the low five bits; host should send zeros.
// - Read and write commands carry data bytes until select is released.
// - Register reads return successive registers from the commanded index.
// - Register writes update successive registers from the commanded index.
// - Each buffer read byte returns and removes the oldest received byte.
// - Each buffer write byte is appended to the buffer in arrival order.
// - Power off acts only with wake pin low and key wake pin high.
// - The clear-interrupt command drives the interrupt output low.
// - Select strap 0 makes select active high, 1 makes it active low.
// - Serial output floats while deselected, unless transparent streaming.
// - Two straps pick clock idle level and sampling edge; host matches.
// - The status register sits at index 16 and reads like any register.
// - Reading status clears wake and supply-low flags and the interrupt.
package scp_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 5;
  localparam int CNT_W = 5;

  localparam logic [2:0] CMD_RD_BUF = 3'h0;
  localparam logic [2:0] CMD_WR_BUF = 3'h1;
  localparam logic [2:0] CMD_RD_REG = 3'h2;
  localparam logic [2:0] CMD_WR_REG = 3'h3;
  localparam logic [2:0] CMD_OFF = 3'h4;
  localparam logic [2:0] CMD_DEL_IRQ = 3'h5;

  localparam logic [ADDR_W-1:0] STATUS_ADDR = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  localparam logic [CNT_W-1:0] MIN_TX_BYTES = 5'h01;
  localparam logic [CNT_W-1:0] THRESH_RST = 5'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  localparam int ST_KEY_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_RAM_BIT = 2;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_RD_BUF,
    ST_WR_BUF,
    ST_RD_REG,
    ST_WR_REG,
    ST_IGNORE
  } scp_state_t;

  typedef struct packed {
    logic cs;
    logic sck;
    logic sdi;
    logic select_polarity_strap;
    logic cpol;
    logic cpha;
    logic wake;
    logic key_n;
  } scp_pins_t;

  typedef struct packed {
    logic [2:0] kind;
    logic [4:0] arg;
  } scp_cmd_t;

endpackage : scp_pkg

// ===== src/scp_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module scp_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : scp_sync
